// ==== include/bgm_pkg.sv ====
// Types shared by the battery gauge measurement core
`default_nettype none
package bgm_pkg;

  // Power modes, one-hot
  typedef enum logic [1:0] {
    BGM_ACTIVE = 2'b01,
    BGM_SLEEP = 2'b10
  } bgm_mode_type;

  // Converter front-end samples
  typedef struct packed {
    logic [11:0] voltage;
    logic signed [10:0] temperature;
    logic signed [17:0] sense;
    logic signed [17:0] offset;
  } bgm_afe_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bgm_avs_req_type;

endpackage
`default_nettype wire

// ==== include/bgm_regs.svh ====
// Register indices, reset values and timing figures of the battery gauge core
`ifndef BGM_REGS_SVH
`define BGM_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define BGM_IDX_STATUS 8'h01
`define BGM_IDX_TEMP 8'h0a
`define BGM_IDX_VOLT 8'h0c
`define BGM_IDX_CURRENT 8'h0e
`define BGM_IDX_ACC 8'h10
`define BGM_IDX_COBIAS 8'h61
`define BGM_IDX_ACCBIAS 8'h62
`define BGM_IDX_MODE 8'h70

// ==========================================================================
// Status/config field positions
`define BGM_ST_PORF 6
`define BGM_ST_SLEEP_EN 5
`define BGM_ST_NBEN 4

// ==========================================================================
// Reset values and fixed codes
`define BGM_RST_STATUS 8'h40
`define BGM_ADDR_HIGH 4'h9
`define BGM_SAT_POS 16'h7fff
`define BGM_SAT_NEG 16'h8000
`define BGM_VOLT_MAX 12'h3ff
`define BGM_ACC_FRAC 12
`define BGM_OFFSET_PERIOD 10

// ==========================================================================
// Timing figures in their own units
`define BGM_CLK_HZ 25000000
`define BGM_T_MEAS_MS 440
`define BGM_T_CONV_MS 3500
`define BGM_T_SLEEP_MS 2000
`define BGM_SAMPLE_HZ 18600

`endif

// ==== verification/bgm_host_model.sv ====
// Host bus master model driving the two sensed lines
`default_nettype none
module bgm_host_model (
  // Line pattern chosen by the bench
  input wire logic [1:0] i_cmd,
  // Sensed bus lines
  output logic o_sda,
  output logic o_scl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_link = 1'b0;
  logic [2:0] pat = 3'h0;
  // ======
  // Link clock, 320 ns, phase unrelated to the core
  initial begin
    #7;
    forever #160 clk_link = ~clk_link;
  end
  // Data moves only while the clock is low
  always @(negedge clk_link) begin
    pat <= pat + 3'h1;
  end
  // Idle pulled up, released to pulldowns, framed traffic, data high alone
  always_comb begin
    case (i_cmd)
      2'd0: {o_sda, o_scl} = 2'b11;
      2'd1: {o_sda, o_scl} = 2'b00;
      2'd2: {o_sda, o_scl} = {pat[1], clk_link};
      default: {o_sda, o_scl} = 2'b10;
    endcase
  end
endmodule
`default_nettype wire

// ==== verification/bgm_measure_sva.sv ====
// Checker for the battery gauge core ports
`default_nettype none
module bgm_measure_sva
  import bgm_pkg::*;
#(
  parameter int unsigned P_SLEEP_CYC = 3000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Watched inputs
  input wire logic i_sda,
  input wire logic i_scl,
  input wire bgm_afe_type i_afe,
  input wire bgm_avs_req_type i_avs,
  // Watched outputs
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [6:0] o_slave_addr,
  input wire logic o_sleeping
);
  logic [31:0] low_cnt;
  logic [3:0] line_hist;
  logic st_wr;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // ======
  // Helpers
  assign st_wr = i_avs.write && !o_avs_waitrequest && i_avs.address == 10'h004;
  // Cycles with both lines low
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_sda || i_scl) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end
  // Recent line activity
  always_ff @(posedge i_clk_sys) begin
    line_hist <= {line_hist[2:0], i_sda | i_scl};
  end
  // ======
  // Assertions
  bus_idle_a: assert property (!(i_avs.read || i_avs.write) |-> !o_avs_waitrequest)
    else $error("wait without request");
  bus_ack_a: assert property ((i_avs.read || i_avs.write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait state");
  rdata_hold_a: assert property (!(i_avs.read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  wake_up_a: assert property (o_sleeping && (i_sda || i_scl) |-> ##[1:4] !o_sleeping)
    else $error("no wake on line high");
  sleep_time_a: assert property ($rose(o_sleeping) |-> low_cnt >= P_SLEEP_CYC)
    else $error("sleep before timeout");
  sleep_exit_a: assert property ($fell(o_sleeping) && !$past(i_reset) |-> line_hist != 4'h0)
    else $error("wake without line activity");
  addr_write_a: assert property ($changed(o_slave_addr) && !$past(i_reset) |-> $past(st_wr))
    else $error("address changed without write");
  addr_high_a: assert property (o_slave_addr[6:3] == 4'h9)
    else $error("fixed address bits wrong");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the battery gauge core
`default_nettype none
`include "bgm_regs.svh"
module tb_top import bgm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned MEAS = 2000;
  localparam int unsigned CONV = 5000;
  localparam int unsigned SLP = 3000;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] host_cmd = 2'd0;
  logic sda, scl, wait_o, sleeping;
  logic [31:0] rdata_o;
  logic [6:0] slave_addr;
  bgm_afe_type afe = {12'h123, 11'h7fe, 18'h0, 18'h0};
  bgm_avs_req_type avs = '0;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  // ======
  // Clock, design and host
  always #20 i_clk_sys = ~i_clk_sys;
  bgm_measure #(.P_MEAS_CYC(MEAS), .P_CONV_CYC(CONV), .P_SLEEP_CYC(SLP)) dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sda(sda), .i_scl(scl), .i_afe(afe), .i_avs(avs),
    .o_avs_readdata(rdata_o), .o_avs_waitrequest(wait_o), .o_slave_addr(slave_addr), .o_sleeping(sleeping));
  bgm_host_model host (.i_cmd(host_cmd), .o_sda(sda), .o_scl(scl));
  // ======
  // Tasks
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    avs.read <= ~wr;
    avs.write <= wr;
    avs.address <= {idx, 2'b00};
    avs.writedata <= {16'h0, wd};
    avs.byteenable <= 4'hf;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wait_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      $display("[ERR] bus answer expected %h seen %h", 1'b0, wait_o);
      err_total++;
    end
    rd = rdata_o;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 16'h0, rd);
    chk(what, exp, rd);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask
  task automatic slp(input string what, input logic exp);
    @(negedge i_clk_sys);
    chk(what, {31'h0, exp}, {31'h0, sleeping});
  endtask
  // Cycle ceiling against a hang
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_total++;
      finish_test();
    end
  end
  // ======
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rc("status", `BGM_IDX_STATUS, 32'h40);
    rc("mode", `BGM_IDX_MODE, 32'h0);
    rc("unmapped", 8'h00, 32'h0);
    @(negedge i_clk_sys);
    chk("address", 32'h48, {25'h0, slave_addr});
    wr(`BGM_IDX_COBIAS, 16'h05);
    wr(`BGM_IDX_ACCBIAS, 16'h03);
    rc("cobias", `BGM_IDX_COBIAS, 32'h05);
    rc("accbias", `BGM_IDX_ACCBIAS, 32'h03);
    // First voltage skipped by waiting two periods
    repeat (2 * MEAS + 100) @(posedge i_clk_sys);
    rc("voltage", `BGM_IDX_VOLT, 32'h2460);
    rc("temperature", `BGM_IDX_TEMP, 32'hffc0);
    afe.voltage <= 12'h400;
    repeat (2 * MEAS + 100) @(posedge i_clk_sys);
    wr(`BGM_IDX_VOLT, 16'h1234);
    rc("overrange", `BGM_IDX_VOLT, 32'h7fff);
    // Zero sense shows the offset bias alone
    repeat (2500) @(posedge i_clk_sys);
    rc("current", `BGM_IDX_CURRENT, 32'h5);
    wr(`BGM_IDX_COBIAS, 16'hfb);
    repeat (CONV) @(posedge i_clk_sys);
    rc("current neg bias", `BGM_IDX_CURRENT, 32'hfffb);
    // Full charge from near the top
    afe.sense <= 18'h20000;
    wr(`BGM_IDX_ACC, 16'hfffe);
    repeat (CONV + 2000) @(posedge i_clk_sys);
    rc("count held", `BGM_IDX_ACC, 32'hfffe);
    rc("current held", `BGM_IDX_CURRENT, 32'hfffb);
    repeat (CONV) @(posedge i_clk_sys);
    rc("current max", `BGM_IDX_CURRENT, 32'h7fff);
    rc("count top", `BGM_IDX_ACC, 32'hffff);
    // Full discharge from near zero
    afe.sense <= 18'h1ffff;
    wr(`BGM_IDX_ACC, 16'h0004);
    repeat (4 * CONV + 1000) @(posedge i_clk_sys);
    rc("current min", `BGM_IDX_CURRENT, 32'h8000);
    rc("count bottom", `BGM_IDX_ACC, 32'h0);
    // Sleep entry and wake
    host_cmd <= 2'd1;
    repeat (SLP + 500) @(posedge i_clk_sys);
    slp("sleep disabled", 1'b0);
    wr(`BGM_IDX_STATUS, 16'h2f);
    rc("status", `BGM_IDX_STATUS, 32'h27);
    @(negedge i_clk_sys);
    chk("address", 32'h4f, {25'h0, slave_addr});
    repeat (SLP - 200) @(posedge i_clk_sys);
    slp("before timeout", 1'b0);
    repeat (300) @(posedge i_clk_sys);
    slp("after timeout", 1'b1);
    rc("mode", `BGM_IDX_MODE, 32'h1);
    wr(`BGM_IDX_ACC, 16'h0100);
    repeat (3 * CONV) @(posedge i_clk_sys);
    rc("count asleep", `BGM_IDX_ACC, 32'h0100);
    rc("current asleep", `BGM_IDX_CURRENT, 32'h8000);
    @(posedge i_clk_sys);
    host_cmd <= 2'd3;
    repeat (5) @(posedge i_clk_sys);
    slp("wake by data", 1'b0);
    @(posedge i_clk_sys);
    host_cmd <= 2'd1;
    repeat (SLP + 100) @(posedge i_clk_sys);
    slp("asleep again", 1'b1);
    @(posedge i_clk_sys);
    host_cmd <= 2'd2;
    repeat (12) @(posedge i_clk_sys);
    slp("wake by clock", 1'b0);
    repeat (2 * CONV + 1000) @(posedge i_clk_sys);
    slp("awake in traffic", 1'b0);
    rc("count after wake", `BGM_IDX_ACC, 32'h00f8);
    finish_test();
  end
endmodule
bind bgm_measure bgm_measure_sva #(.P_SLEEP_CYC(P_SLEEP_CYC)) chk_u (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sda(i_sda), .i_scl(i_scl), .i_afe(i_afe), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_slave_addr(o_slave_addr),
  .o_sleeping(o_sleeping));
`default_nettype wire

// ==== verilog/bgm_measure.sv ====
// Battery gauge measurement, coulomb counting and power mode core
// Summary of operation
// RULE_01: Any bus line high wakes to active
// RULE_02: Sleep needs enable bit and lines low
// RULE_03: Both lines low about two seconds
// RULE_04: Sleep enable reads zero after reset
// RULE_05: Sleep halts conversions, registers stay accessible
// RULE_06: Active converts continuously, all registers accessible
// RULE_07: Voltage every 440 ms, 4.88 mV step
// RULE_08: Voltage overrange reads 7FFFh
// RULE_09: Host discards first voltage after reset/write
// RULE_10: Temperature every 440 ms, 0.125 degree
// RULE_11: Current signed, 1.56 uV step
// RULE_12: Sense below ground gives positive current
// RULE_13: 18.6 kHz sampling, update per conversion
// RULE_14: Current saturates 7FFFh and 8000h
// RULE_15: Every 1024th conversion measures converter offset
// RULE_16: Offset conversion keeps and reuses previous current; a forced one after a count write adds nothing
// RULE_17: Current plus bias accumulated each conversion; the code skips the forced offset conversion after a count write
// RULE_18: New count is current+bias+old count
// RULE_19: Count clamps FFFFh and 0000h, no wrap
// RULE_20: Hidden fraction cleared on count write
// RULE_21: Count write forces offset, resumes second conversion
// RULE_22: Current shows raw plus offset bias
// RULE_23: Offset bias signed, applies after write
// RULE_24: Host reloads offset bias after power-up
// RULE_25: Host may change the slave address
// RULE_26: Timing from internal free-running time base
`default_nettype none
`include "bgm_regs.svh"

module bgm_measure
  import bgm_pkg::*;
#(
  parameter int unsigned P_MEAS_CYC = `BGM_T_MEAS_MS * (`BGM_CLK_HZ / 1000),
  parameter int unsigned P_CONV_CYC = `BGM_T_CONV_MS * (`BGM_CLK_HZ / 1000),
  parameter int unsigned P_SLEEP_CYC = `BGM_T_SLEEP_MS * (`BGM_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Two-wire bus lines, sensed only
  input wire logic i_sda,
  input wire logic i_scl,
  // Converter front end
  input wire bgm_afe_type i_afe,
  // Avalon-MM slave
  input wire bgm_avs_req_type i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Status outputs
  output logic [6:0] o_slave_addr,
  output logic o_sleeping
);

  // ========================================================================
  // Derived counts
  localparam int unsigned SAMPLE_CYC = `BGM_CLK_HZ / `BGM_SAMPLE_HZ;

  // ========================================================================
  // Declarations
  logic sda_meta, sda_sync, scl_meta, scl_sync;
  bgm_mode_type mode;
  logic [25:0] sleep_cnt;
  logic [10:0] sample_cnt;
  logic [23:0] meas_cnt;
  logic [26:0] conv_cnt;
  logic [9:0] conv_idx;
  logic sample_tick, meas_tick, conv_tick, active;
  logic signed [17:0] sense_avg, offset_avg, offset_corr;
  logic signed [18:0] sense_diff, offset_diff;
  logic signed [17:0] next_sense_avg, next_offset_avg;
  logic signed [19:0] raw_current;
  logic [15:0] next_current;
  logic [15:0] current, voltage, temperature;
  logic [7:0] cobias, accbias, status;
  logic [27:0] acc;
  logic signed [16:0] acc_step;
  logic signed [29:0] acc_sum;
  logic [27:0] next_acc;
  logic force_offset, offset_conv;
  logic ack, wr_en;
  logic [7:0] idx;

  // ========================================================================
  // Helper functions
  function automatic logic [15:0] bgm_sat16(input logic signed [19:0] v);
    if (v > 20'sh07fff) begin
      return `BGM_SAT_POS;
    end else if (v < -20'sh08000) begin
      return `BGM_SAT_NEG;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] bgm_merge16(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ========================================================================
  // Bus line synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sda_meta <= 1'b0;
      sda_sync <= 1'b0;
      scl_meta <= 1'b0;
      scl_sync <= 1'b0;
    end else begin
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
    end
  end

  // ========================================================================
  // Power mode
  // Idle timer counts while enabled and both lines low
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || sda_sync || scl_sync || !status[`BGM_ST_SLEEP_EN]) begin
      sleep_cnt <= 26'h0; // [RULE_02]
    end else if (mode == BGM_ACTIVE) begin
      sleep_cnt <= sleep_cnt + 26'h1; // [RULE_03]
    end
  end

  // Mode transitions
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mode <= BGM_ACTIVE;
    end else begin
      unique case (mode)
        BGM_ACTIVE: begin
          if (status[`BGM_ST_SLEEP_EN] && !sda_sync && !scl_sync &&
              sleep_cnt == 26'(P_SLEEP_CYC - 1)) begin
            mode <= BGM_SLEEP; // [RULE_02] [RULE_03]
          end
        end
        BGM_SLEEP: begin
          if (sda_sync || scl_sync) begin
            mode <= BGM_ACTIVE; // [RULE_01]
          end
        end
        default: mode <= BGM_ACTIVE;
      endcase
    end
  end

  assign active = (mode == BGM_ACTIVE);
  assign o_sleeping = (mode == BGM_SLEEP);

  // ========================================================================
  // Internal time base, frozen in sleep
  assign sample_tick = active && (sample_cnt == 11'(SAMPLE_CYC - 1));
  assign meas_tick = active && (meas_cnt == 24'(P_MEAS_CYC - 1));
  assign conv_tick = active && (conv_cnt == 27'(P_CONV_CYC - 1));

  // Converter sample clock divider
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || sample_tick) begin
      sample_cnt <= 11'h0; // [RULE_13] [RULE_26]
    end else if (active) begin
      sample_cnt <= sample_cnt + 11'h1; // [RULE_05]
    end
  end

  // Voltage and temperature period
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || meas_tick) begin
      meas_cnt <= 24'h0; // [RULE_26]
    end else if (active) begin
      meas_cnt <= meas_cnt + 24'h1; // [RULE_06]
    end
  end

  // Current conversion period, restarted by a count write
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || conv_tick || (wr_en && idx == `BGM_IDX_ACC)) begin
      conv_cnt <= 27'h0; // [RULE_21]
    end else if (active) begin
      conv_cnt <= conv_cnt + 27'h1; // [RULE_05]
    end
  end

  // Conversion index, zero marks the offset conversion
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      conv_idx <= 10'h0;
    end else if (conv_tick) begin
      conv_idx <= conv_idx + 10'h1; // [RULE_15]
    end
  end

  // ========================================================================
  // Sense and offset filtering at the sample rate
  assign sense_diff = {i_afe.sense[17], i_afe.sense} - {sense_avg[17], sense_avg};
  assign offset_diff = {i_afe.offset[17], i_afe.offset} - {offset_avg[17], offset_avg};
  assign next_sense_avg = 18'($signed({sense_avg[17], sense_avg}) + (sense_diff >>> 4));
  assign next_offset_avg = 18'($signed({offset_avg[17], offset_avg}) + (offset_diff >>> 4));

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sense_avg <= 18'sh0;
      offset_avg <= 18'sh0;
    end else if (sample_tick) begin
      sense_avg <= next_sense_avg; // [RULE_13]
      offset_avg <= next_offset_avg;
    end
  end

  // ========================================================================
  // Current result: sign flipped, offset removed, bias added, saturated
  assign offset_conv = force_offset || (conv_idx == 10'h0);
  assign raw_current = {{2{offset_corr[17]}}, offset_corr} - {{2{sense_avg[17]}}, sense_avg}; // [RULE_12]
  assign next_current = bgm_sat16(raw_current + {{12{cobias[7]}}, cobias}); // [RULE_14] [RULE_22] [RULE_23]

  // Offset correction factor and current register
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      offset_corr <= 18'sh0;
      current <= 16'h0;
    end else if (conv_tick) begin
      if (offset_conv) begin
        offset_corr <= offset_avg; // [RULE_15] [RULE_16]
      end else begin
        current <= next_current; // [RULE_11] [RULE_13]
      end
    end
  end

  // Forced offset measurement after a count write
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      force_offset <= 1'b0;
    end else if (wr_en && idx == `BGM_IDX_ACC) begin
      force_offset <= 1'b1; // [RULE_21]
    end else if (conv_tick) begin
      force_offset <= 1'b0;
    end
  end

  // ========================================================================
  // Voltage and temperature registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      voltage <= 16'h0;
      temperature <= 16'h0;
    end else if (meas_tick) begin
      if (i_afe.voltage > `BGM_VOLT_MAX) begin
        voltage <= `BGM_SAT_POS; // [RULE_08]
      end else begin
        voltage <= {i_afe.voltage[10:0], 5'h0}; // [RULE_07]
      end
      temperature <= {i_afe.temperature, 5'h0}; // [RULE_10]
    end
  end

  // ========================================================================
  // Charge accumulation with hidden fraction
  // Fresh result on a normal conversion, held result on an offset conversion
  assign acc_step = offset_conv ? ({current[15], current} + {{9{accbias[7]}}, accbias})
                                : ({next_current[15], next_current} + {{9{accbias[7]}}, accbias}); // [RULE_17] [RULE_22]
  assign acc_sum = $signed({2'b00, acc}) + {{13{acc_step[16]}}, acc_step}; // [RULE_18]

  always_comb begin
    if (acc_sum[29]) begin
      next_acc = 28'h0; // [RULE_19]
    end else if (acc_sum[28]) begin
      next_acc = 28'hfffffff; // [RULE_19]
    end else begin
      next_acc = acc_sum[27:0];
    end
  end

  // Host write wins over an accumulation in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      acc <= 28'h0;
    end else if (wr_en && idx == `BGM_IDX_ACC) begin
      acc <= {bgm_merge16(acc[27:`BGM_ACC_FRAC], i_avs.writedata, i_avs.byteenable),
              12'h0}; // [RULE_20]
    end else if (conv_tick && !force_offset) begin
      acc <= next_acc; // [RULE_16] [RULE_17]
    end
  end

  // ========================================================================
  // Avalon-MM slave, one wait state per access
  assign idx = i_avs.address[9:2];
  assign wr_en = i_avs.write && ack;
  assign o_avs_waitrequest = (i_avs.read || i_avs.write) && !ack;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs.read || i_avs.write) && !ack;
    end
  end

  // Status/config, bias registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      status <= `BGM_RST_STATUS; // [RULE_04]
      cobias <= 8'h0;
      accbias <= 8'h0;
    end else if (wr_en && i_avs.byteenable[0]) begin
      unique case (idx)
        `BGM_IDX_STATUS: begin
          status[`BGM_ST_PORF] <= status[`BGM_ST_PORF] & i_avs.writedata[`BGM_ST_PORF];
          status[`BGM_ST_SLEEP_EN] <= i_avs.writedata[`BGM_ST_SLEEP_EN]; // [RULE_02]
          status[`BGM_ST_NBEN] <= i_avs.writedata[`BGM_ST_NBEN];
          status[2:0] <= i_avs.writedata[2:0]; // [RULE_25]
        end
        `BGM_IDX_COBIAS: cobias <= i_avs.writedata[7:0]; // [RULE_23]
        `BGM_IDX_ACCBIAS: accbias <= i_avs.writedata[7:0];
        default: ;
      endcase
    end
  end

  assign o_slave_addr = {`BGM_ADDR_HIGH, status[2:0]}; // [RULE_25]

  // Read data, registered during the wait state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs.read && !ack) begin
      unique case (idx)
        `BGM_IDX_STATUS: o_avs_readdata <= {24'h0, 1'b0, status[6:4], 1'b0, status[2:0]};
        `BGM_IDX_TEMP: o_avs_readdata <= {16'h0, temperature};
        `BGM_IDX_VOLT: o_avs_readdata <= {16'h0, voltage};
        `BGM_IDX_CURRENT: o_avs_readdata <= {16'h0, current};
        `BGM_IDX_ACC: o_avs_readdata <= {16'h0, acc[27:`BGM_ACC_FRAC]};
        `BGM_IDX_COBIAS: o_avs_readdata <= {24'h0, cobias};
        `BGM_IDX_ACCBIAS: o_avs_readdata <= {24'h0, accbias};
        `BGM_IDX_MODE: o_avs_readdata <= {31'h0, o_sleeping};
        default: o_avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire
